// [rtl/clkcfg_regs.sv]
`timescale 1ns/1ps
// What this block does
// - byte 3 enables 66M, interrupt and host clocks
// - byte 4 enables memory clocks 7 to 0
// - byte 5 feedback and clocks 11-8, reserved zero
// - byte 6 returns fixed revision and maker nibbles
// - byte 7 bits 6,5 pick usb drive
// - byte 7 bits 3,2 enable usb clocks
// - byte 8 bits 7-6 pci skew, reset 00
// - byte 9 bit 7 memory clock drive
// - byte 9 bit 6 pci/agp drive, rest zero
// - byte 10 bits 7-5 host clock skew
// - byte 10 bits 4-2 memory clock skew
// - byte 10 bits 1-0 graphics clock skew
// - bytes 11 to 14 reserved, read zero
// - command top bit marks byte access, offset below
module clkcfg_regs (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [clkcfg_pkg::NUM_OUTS-1:0] raw_clk_in,
  output logic [clkcfg_pkg::NUM_OUTS-1:0] gated_clk_out,
  output clkcfg_pkg::clk_ctrl_t ctrl_out
);
  import clkcfg_pkg::*;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  logic scl_lvl; // sampled clock line
  logic scl_rise; // clock line went high
  logic scl_fall; // clock line went low
  logic sda_lvl; // sampled data line
  logic sda_rise; // data line went high
  logic sda_fall; // data line went low
  logic start_det; // start or repeated start
  logic stop_det; // stop condition
  logic in_byte; // a byte phase is active
  logic bit_edge; // data bit clocked in
  logic ack_start; // eighth bit done, slot begins
  logic ack_end; // acknowledge slot done
  logic addr_hit; // address matches this device
  logic in_range; // pointer lands in this bank
  logic [3:0] idx; // pointer relative to byte 3
  logic [7:0] rd_data; // byte under the pointer

  bus_state_t state_ff; // serial phase
  logic [3:0] cnt_ff; // bits seen in this byte
  logic ack_ff; // inside the ninth bit slot
  logic [7:0] shift_ff; // serial shifter, both ways
  logic rw_ff; // direction bit of the address
  logic [6:0] off_ff; // byte pointer from command
  logic oe_ff; // pulling the data line low
  logic wr_ff; // one-cycle write strobe
  logic [7:0] wdata_ff; // byte to write
  logic [7:0] cfg_ff [NUM_BYTES]; // configuration bytes

  // line samplers for both serial pins
  line_edge u_scl_edge (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .line_in(scl_in),
    .level_out(scl_lvl),
    .rise_out(scl_rise),
    .fall_out(scl_fall)
  );

  line_edge u_sda_edge (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .line_in(sda_in),
    .level_out(sda_lvl),
    .rise_out(sda_rise),
    .fall_out(sda_fall)
  );

  // both lines pass equal delay, so edges line up
  assign start_det = sda_fall & scl_lvl;
  assign stop_det = sda_rise & scl_lvl;

  // qualifiers shared by the sequencer and datapath
  assign in_byte = (state_ff != ST_IDLE) && (state_ff != ST_SKIP);
  assign bit_edge = scl_rise & ~ack_ff & in_byte &
    (cnt_ff < BITS_PER_BYTE);
  assign ack_start = scl_fall & ~ack_ff & in_byte &
    (cnt_ff == BITS_PER_BYTE);
  assign ack_end = scl_fall & ack_ff;
  assign addr_hit = (shift_ff[7:1] == SLAVE_ADDR);

  // read mux; outside the bank the answer is zero
  assign in_range = (off_ff >= OFF_FIRST) && (off_ff <= OFF_LAST);
  assign idx = 4'(off_ff - OFF_FIRST);

  always_comb begin
    rd_data = 8'h00;
    if (in_range) begin
      rd_data = cfg_ff[idx];
    end
  end

  // serial phase sequencer
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
    end else if (start_det) begin
      // repeated start keeps the byte pointer
      state_ff <= ST_ADDR;
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
    end else if (bit_edge) begin
      cnt_ff <= cnt_ff + 4'h1;
    end else if (ack_start) begin
      case (state_ff)
        ST_ADDR: begin
          // foreign address: stay off the bus
          if (addr_hit) begin
            ack_ff <= 1'b1;
          end else begin
            state_ff <= ST_SKIP;
          end
        end
        ST_CMD: begin
          // only byte commands are taken
          if (shift_ff[7]) begin
            ack_ff <= 1'b1;
          end else begin
            state_ff <= ST_SKIP;
          end
        end
        default: begin
          ack_ff <= 1'b1;
        end
      endcase
    end else if (ack_end) begin
      ack_ff <= 1'b0;
      cnt_ff <= 4'h0;
      case (state_ff)
        ST_ADDR: begin
          state_ff <= rw_ff ? ST_RDATA : ST_CMD;
        end
        ST_CMD: begin
          state_ff <= ST_WDATA;
        end
        default: begin
          // single byte per access; rest ignored till stop or start
          state_ff <= ST_SKIP;
        end
      endcase
    end
  end

  // shifter: loads the read byte, else shifts on rise
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      shift_ff <= 8'h00;
    end else if (ack_end && state_ff == ST_ADDR && rw_ff) begin
      shift_ff <= rd_data;
    end else if (bit_edge) begin
      shift_ff <= {shift_ff[6:0], sda_lvl};
    end
  end

  // direction bit, caught when the address is taken
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rw_ff <= 1'b0;
    end else if (ack_start && state_ff == ST_ADDR && addr_hit) begin
      rw_ff <= shift_ff[0];
    end
  end

  // byte pointer from the low seven command bits
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      off_ff <= 7'h00;
    end else if (ack_start && state_ff == ST_CMD && shift_ff[7]) begin
      off_ff <= shift_ff[6:0];
    end
  end

  // write strobe with its data byte
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wr_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else begin
      wr_ff <= ack_start && (state_ff == ST_WDATA);
      if (ack_start && state_ff == ST_WDATA) begin
        wdata_ff <= shift_ff;
      end
    end
  end

  // data line driver; changes only while the clock is low
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      oe_ff <= 1'b0;
    end else if (start_det || stop_det) begin
      oe_ff <= 1'b0;
    end else if (ack_start) begin
      // acknowledge own address, byte command and write data; host owns the slot after a read
      case (state_ff)
        ST_ADDR: oe_ff <= addr_hit;
        ST_CMD: oe_ff <= shift_ff[7];
        ST_WDATA: oe_ff <= 1'b1;
        default: oe_ff <= 1'b0;
      endcase
    end else if (ack_end) begin
      // first read bit goes out as the slot ends
      if (state_ff == ST_ADDR && rw_ff) begin
        oe_ff <= ~rd_data[7];
      end else begin
        oe_ff <= 1'b0;
      end
    end else if (scl_fall && state_ff == ST_RDATA && !ack_ff) begin
      oe_ff <= ~shift_ff[7];
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_out = oe_ff;

  // configuration bytes; masked bits keep reset value
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NUM_BYTES; i++) begin
        cfg_ff[i] <= RST_VAL[i];
      end
    end else if (wr_ff && in_range) begin
      // read-only and reserved bits have a zero mask
      cfg_ff[idx] <= (cfg_ff[idx] & ~WR_MASK[idx]) |
        (wdata_ff & WR_MASK[idx]);
    end
  end

  // decode of the held bytes into named controls
  always_comb begin
    ctrl_out.agp_rate_en = cfg_ff[0][7:5];
    ctrl_out.interrupt_ctrl_clk_en = cfg_ff[0][4];
    ctrl_out.host_clk_en = cfg_ff[0][1:0];
    ctrl_out.memclk_en[7:0] = cfg_ff[1];
    ctrl_out.memclk_fb_en = cfg_ff[2][4];
    ctrl_out.memclk_en[11:8] = cfg_ff[2][3:0];
    ctrl_out.dual_rate_usb_drive = cfg_ff[4][6];
    ctrl_out.usb_rate_drive = cfg_ff[4][5];
    ctrl_out.dual_rate_usb_en = cfg_ff[4][3];
    ctrl_out.usb_rate_en = cfg_ff[4][2];
    ctrl_out.pci_delay_trim = cfg_ff[5][7:6];
    ctrl_out.memclk_drive_sel = cfg_ff[6][7];
    ctrl_out.pci_agp_drive_sel = cfg_ff[6][6];
    ctrl_out.host_delay_trim = cfg_ff[7][7:5];
    ctrl_out.mem_delay_trim = cfg_ff[7][4:2];
    ctrl_out.graphics_delay_trim = cfg_ff[7][1:0];
  end

  // per-output gating; order matches the enable vector
  out_gate #(
    .WIDTH(NUM_OUTS)
  ) u_out_gate (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .en_in({ctrl_out.agp_rate_en, ctrl_out.interrupt_ctrl_clk_en,
      ctrl_out.host_clk_en, ctrl_out.memclk_fb_en, ctrl_out.memclk_en,
      ctrl_out.dual_rate_usb_en, ctrl_out.usb_rate_en}),
    .raw_in(raw_clk_in),
    .clk_out(gated_clk_out)
  );

  // byte 3 write reaches the enables one cycle later
  AST_B3_WRITE: assert property ((wr_ff && off_ff == OFF_B3) |=>
    (ctrl_out.agp_rate_en == $past(wdata_ff[7:5]) &&
     ctrl_out.host_clk_en == $past(wdata_ff[1:0])))
    else $error("byte 3 enables do not follow write");

  // memory clocks come out of reset all enabled
  AST_B4_RESET: assert property ($fell(sys_rst_in) |->
    (ctrl_out.memclk_en == 12'hfff && ctrl_out.memclk_fb_en))
    else $error("memory clock enables not set after reset");

  // reserved top bits of byte 5 always read zero
  AST_B5_RSVD: assert property ((off_ff == OFF_B5) |->
    (rd_data[7:5] == 3'h0))
    else $error("byte 5 reserved bits not zero");

  // identification byte never changes, even after writes
  AST_IDENT_FIXED: assert property ((off_ff == OFF_B6) |->
    (rd_data == {REV_IDENT, MAKER_IDENT}))
    else $error("identification byte changed");

  // write to identification byte leaves it unchanged
  AST_IDENT_WRITE: assert property ((wr_ff && off_ff == OFF_B6) |=>
    (cfg_ff[3] == $past(cfg_ff[3])))
    else $error("identification byte took a write");

  // usb drive and enables reset high, reserved bits zero
  AST_B7_RESET: assert property ($fell(sys_rst_in) |->
    (ctrl_out.dual_rate_usb_drive && ctrl_out.usb_rate_drive &&
     ctrl_out.dual_rate_usb_en && ctrl_out.usb_rate_en))
    else $error("byte 7 reset values wrong");

  AST_B7_RSVD: assert property ((off_ff == OFF_B7) |->
    ((rd_data & 8'h93) == 8'h00))
    else $error("byte 7 reserved bits not zero");

  // pci skew follows write, reserved middle bits stay one
  AST_B8_WRITE: assert property ((wr_ff && off_ff == OFF_B8) |=>
    (ctrl_out.pci_delay_trim == $past(wdata_ff[7:6]) &&
     cfg_ff[5][5:0] == 6'h3e))
    else $error("byte 8 skew or reserved bits wrong");

  // drive selects follow a byte 9 write, low bits stay zero
  AST_B9_WRITE: assert property ((wr_ff && off_ff == OFF_B9) |=>
    (ctrl_out.memclk_drive_sel == $past(wdata_ff[7]) &&
     ctrl_out.pci_agp_drive_sel == $past(wdata_ff[6]) &&
     cfg_ff[6][5:0] == 6'h00))
    else $error("byte 9 drive selects wrong");

  // all three skew fields take the written byte whole
  AST_B10_WRITE: assert property (
    (wr_ff && off_ff == OFF_B10) |=>
    ({ctrl_out.host_delay_trim, ctrl_out.mem_delay_trim,
      ctrl_out.graphics_delay_trim} == $past(wdata_ff)))
    else $error("byte 10 skew fields wrong");

  // reserved bytes read zero whatever was written
  AST_SPARE_ZERO: assert property ((off_ff >= OFF_B11 &&
    off_ff <= OFF_LAST) |-> (rd_data == 8'h00))
    else $error("reserved byte not zero");

  // a command without the byte mark is refused, bus released
  AST_CMD_REFUSE: assert property (
    (ack_start && state_ff == ST_CMD && !shift_ff[7]) |=>
    (state_ff == ST_SKIP && !sda_oe_out)[*2])
    else $error("non-byte command was acknowledged");

  // main scenarios
  COV_WRITE: cover property (wr_ff && off_ff == OFF_B10);
  COV_READ: cover property (ack_end && state_ff == ST_RDATA);
  COV_FOREIGN: cover property (ack_start && state_ff == ST_ADDR &&
    !addr_hit);
  COV_STOPPED: cover property (!ctrl_out.memclk_en[0] &&
    $fell(gated_clk_out[2]));
endmodule

// [rtl/clkcfg_pkg.sv]
package clkcfg_pkg;
  // serial address that this device answers to
  localparam logic [6:0] SLAVE_ADDR = 7'h69;
  // byte offsets of the configuration map held here
  localparam logic [6:0] OFF_FIRST = 7'h03;
  localparam logic [6:0] OFF_LAST = 7'h0e;
  localparam logic [6:0] OFF_B3 = 7'h03;
  localparam logic [6:0] OFF_B4 = 7'h04;
  localparam logic [6:0] OFF_B5 = 7'h05;
  localparam logic [6:0] OFF_B6 = 7'h06;
  localparam logic [6:0] OFF_B7 = 7'h07;
  localparam logic [6:0] OFF_B8 = 7'h08;
  localparam logic [6:0] OFF_B9 = 7'h09;
  localparam logic [6:0] OFF_B10 = 7'h0a;
  localparam logic [6:0] OFF_B11 = 7'h0b;
  localparam int NUM_BYTES = 12;
  // identification nibbles; values are arbitrary
  localparam logic [3:0] REV_IDENT = 4'h2;
  localparam logic [3:0] MAKER_IDENT = 4'h5;
  // bits per serial byte before the acknowledge slot
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // number of gated clock outputs
  localparam int NUM_OUTS = 21;
  // bits that software may change, index 0 is byte 3
  localparam logic [7:0] WR_MASK [NUM_BYTES] = '{
    8'hf3, 8'hff, 8'h1f, 8'h00, 8'h6c, 8'hc0,
    8'hc0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  // value of each byte after reset
  localparam logic [7:0] RST_VAL [NUM_BYTES] = '{
    8'hf3, 8'hff, 8'h1f, {REV_IDENT, MAKER_IDENT}, 8'h6c, 8'h3e,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // decoded configuration handed to the clock outputs
  typedef struct packed {
    logic [2:0] agp_rate_en;
    logic interrupt_ctrl_clk_en;
    logic [1:0] host_clk_en;
    logic memclk_fb_en;
    logic [11:0] memclk_en;
    logic dual_rate_usb_en;
    logic usb_rate_en;
    logic dual_rate_usb_drive;
    logic usb_rate_drive;
    logic memclk_drive_sel;
    logic pci_agp_drive_sel;
    logic [1:0] pci_delay_trim;
    logic [2:0] host_delay_trim;
    logic [2:0] mem_delay_trim;
    logic [1:0] graphics_delay_trim;
  } clk_ctrl_t;
  // serial slave phases
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_SKIP
  } bus_state_t;
endpackage

// [rtl/line_edge.sv]
`timescale 1ns/1ps
// samples one serial line and reports its edges
module line_edge (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic line_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic meta_ff; // first stage, read only by the second
  logic sync_ff; // settled level
  logic prev_ff; // level one cycle earlier

  // two stages then a history flop for edge detection
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= line_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign rise_out = sync_ff & ~prev_ff;
  assign fall_out = ~sync_ff & prev_ff;
endmodule

// [rtl/out_gate.sv]
`timescale 1ns/1ps
// stops each clock output low while its enable is clear
module out_gate #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] en_in,
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] clk_out
);
  logic [WIDTH-1:0] hold_ff; // enable taken only while low

  // enable changes only in the low phase, so no runt pulse
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      hold_ff <= '0;
    end else begin
      hold_ff <= (hold_ff & raw_in) | (en_in & ~raw_in);
    end
  end

  // registered gated output
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      clk_out <= '0;
    end else begin
      clk_out <= raw_in & hold_ff;
    end
  end

  // a disabled output caught low stays low two more cycles
  AST_GATE_STOPS_LOW: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in) (|(~en_in & ~raw_in)) |-> ##2
    ((clk_out & $past(~en_in & ~raw_in, 2)) == '0))
    else $error("disabled clock output not held low");
endmodule

// [tb/smbus_host.sv]
`timescale 1ns/1ps
// behavioural serial host; it only pulls the data line low or lets go,
// so a released line reads high through the pull-up
module smbus_host (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_lo_out
);
  // idle bus: clock high, data released
  initial begin
    scl_out = 1'b1;
    sda_lo_out = 1'b0;
  end
  // wait whole core cycles
  task automatic tk(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // one bit slot; data moves mid-low, far from both clock edges
  task automatic bit_io(input logic b, output logic r);
    tk(5);
    sda_lo_out <= ~b;
    tk(5);
    scl_out <= 1'b1;
    tk(6);
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    tk(5);
    sda_lo_out <= 1'b0;
    tk(5);
    scl_out <= 1'b1;
    tk(6);
    sda_lo_out <= 1'b1;
    tk(6);
    scl_out <= 1'b0;
  endtask
  // stop: data rises while clock high, then bus idles
  task automatic stop();
    tk(5);
    sda_lo_out <= 1'b1;
    tk(5);
    scl_out <= 1'b1;
    tk(6);
    sda_lo_out <= 1'b0;
    tk(10);
  endtask
  // eight bits msb first, then the device's acknowledge slot
  task automatic send(input logic [7:0] b, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ak = ~r;
  endtask
  // byte write: address, command, one data byte
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d,
                    input logic [6:0] adr, output logic [2:0] ak);
    start();
    send({adr, 1'b0}, ak[2]);
    send(cmd, ak[1]);
    send(d, ak[0]);
    stop();
  endtask
  // byte read; the closing not-acknowledge ends the transfer
  task automatic rd(input logic [7:0] cmd, output logic [7:0] d,
                    output logic ak);
    logic [2:0] a;
    logic r;
    start();
    send({clkcfg_pkg::SLAVE_ADDR, 1'b0}, a[2]);
    send(cmd, a[1]);
    start();
    send({clkcfg_pkg::SLAVE_ADDR, 1'b1}, a[0]);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, r);
    stop();
    ak = &a;
  endtask
  // read at the pointer left by the last command, no command byte
  task automatic rd_cur(output logic [7:0] d, output logic ak);
    logic r;
    start();
    send({clkcfg_pkg::SLAVE_ADDR, 1'b1}, ak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, r);
    stop();
  endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import clkcfg_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [NUM_OUTS-1:0] raw_clk = '0;
  logic scl;
  logic sda_lo;
  logic sda_oe;
  logic sda_dev;
  // wired-and data line with pull-up
  wire sda_wire = ~(sda_lo | sda_oe);
  logic [NUM_OUTS-1:0] gated;
  clk_ctrl_t ctrl;
  int error_cnt = 0;
  int n_tests = 0;
  int mdl [16];
  logic [31:0] rng = 32'hd770;
  // 250 MHz core clock
  always #2 core_clk = ~core_clk;
  clkcfg_regs DUT (.core_clk_in(core_clk), .sys_rst_in(sys_rst),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_dev),
    .sda_oe_out(sda_oe), .raw_clk_in(raw_clk), .gated_clk_out(gated),
    .ctrl_out(ctrl));
  smbus_host host (.clk_in(core_clk), .sda_in(sda_wire),
    .scl_out(scl), .sda_lo_out(sda_lo));
  // pseudo-random source
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // bits that a host write may change in each byte
  function automatic int msk(input int o);
    case (o)
      3: return 8'hf3;
      4: return 8'hff;
      5: return 8'h1f;
      7: return 8'h6c;
      8: return 8'hc0;
      9: return 8'hc0;
      10: return 8'hff;
      default: return 0;
    endcase
  endfunction
  // model contents after reset
  task automatic mdl_rst();
    mdl = '{default: 0};
    mdl[3] = 8'hf3;
    mdl[4] = 8'hff;
    mdl[5] = 8'h1f;
    mdl[6] = {REV_IDENT, MAKER_IDENT};
    mdl[7] = 8'h6c;
    mdl[8] = 8'h3e;
  endtask
  // decoded fields expected from the model bytes
  function automatic logic [39:0] ctrl_exp();
    return 40'({mdl[3][7:5], mdl[3][4], mdl[3][1:0], mdl[5][4:0],
      mdl[4][7:0], mdl[7][3], mdl[7][2], mdl[7][6], mdl[7][5],
      mdl[9][7], mdl[9][6], mdl[8][7:6], mdl[10][7:5], mdl[10][4:2],
      mdl[10][1:0]});
  endfunction
  // per-output enables in output bit order
  function automatic logic [NUM_OUTS-1:0] en_exp();
    return {mdl[3][7:5], mdl[3][4], mdl[3][1:0], mdl[5][4:0],
      mdl[4][7:0], mdl[7][3], mdl[7][2]};
  endfunction
  // one comparison
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // gating: park raw low so enables settle, then apply a random pattern
  task automatic chk_gate();
    logic [NUM_OUTS-1:0] r;
    @(posedge core_clk);
    raw_clk <= '0;
    repeat (3) @(posedge core_clk);
    rng = nxt(rng);
    r = rng[NUM_OUTS-1:0];
    raw_clk <= r;
    repeat (3) @(posedge core_clk);
    chk(40'(gated), 40'(r & en_exp()));
  endtask
  // read every byte back and compare outputs with the model
  task automatic chk_all();
    logic [7:0] d;
    logic a;
    for (int o = 3; o <= 14; o++) begin
      host.rd({1'b1, 7'(o)}, d, a);
      chk(40'(a), 40'h1);
      chk(40'(d), 40'(mdl[o]));
    end
    chk(40'(ctrl), ctrl_exp());
    chk(40'(sda_dev), 40'h0);
    chk_gate();
  endtask
  // byte write through the bus, mirrored into the model
  task automatic wr_chk(input int o, input logic [7:0] d);
    logic [2:0] ak;
    host.wr({1'b1, 7'(o)}, d, SLAVE_ADDR, ak);
    chk(40'(ak), 40'h7);
    if (o >= 3 && o <= 14) begin
      mdl[o] = (mdl[o] & ~msk(o)) | (int'(d) & msk(o));
    end
  endtask
  // main sequence
  initial begin
    logic [7:0] d;
    logic [2:0] ak;
    logic a;
    mdl_rst();
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk_all();
    // random contents; compliant host keeps reserved bits as required
    for (int p = 0; p < 2; p++) begin
      for (int o = 3; o <= 16; o++) begin
        rng = nxt(rng);
        d = rng[7:0];
        if (o != 6 && o <= 14) begin
          d = (d & 8'(msk(o))) | (o == 8 ? 8'h3e : 8'h00);
        end
        wr_chk(o, d);
      end
      chk_all();
    end
    // every skew code of each field
    for (int i = 0; i < 8; i++) begin
      wr_chk(10, {3'(i), 3'(i), 2'(i)});
      wr_chk(8, {2'(i), 6'h3e});
      chk(40'(ctrl), ctrl_exp());
    end
    // read with no command reuses the byte 8 pointer
    host.rd_cur(d, a);
    chk(40'({a, d}), 40'({1'b1, 8'(mdl[8])}));
    // non-byte command, foreign address, unmapped offset
    host.wr(8'h0a, 8'hff, SLAVE_ADDR, ak);
    chk(40'(ak[1]), 40'h0);
    host.wr(8'h8a, 8'hff, SLAVE_ADDR ^ 7'h01, ak);
    chk(40'(ak[2]), 40'h0);
    host.rd(8'ha0, d, a);
    chk(40'(d), 40'h0);
    chk_all();
    // second reset in mid-run
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    mdl_rst();
    repeat (4) @(posedge core_clk);
    chk_all();
    wrap_up();
  end
  // watchdog against a hung bus
  initial begin
    repeat (90000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end
  // verdict and end of run
  task automatic wrap_up();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
endmodule
